/* File: pit_interval_timer.sv */
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module pit_interval_timer #(
  parameter int unsigned PULSE_CYC = pit_pkg::PIT_PULSE_CYC,  // cycles per fast pulse
  parameter logic [15:0] ID_VALUE  = 16'h00a5                 // arbitrary id value
) (
  input  wire logic               clk,
  input  wire logic               rst,
  // classic wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // programmed-I/O operatives from the processor
  input  wire logic               pio_valid,
  input  pit_pkg::pit_oper_s      pio_op,
  input  wire logic [15:0]        backplane_data_lines,
  output pit_pkg::pit_reply_s     pio_reply,
  // interrupt path
  input  wire logic               irq_ack,
  output logic                    irq_req,
  output logic                    timing_pulse,
  output logic      [15:0]        backplane_address_lines,
  output logic                    vector_valid
);
  import pit_pkg::*;

  // ****************************************************************
  // elaboration checks and derived counts
  // ****************************************************************
  localparam int unsigned CNT_W = 18;

  if (PULSE_CYC < 2 || 2 * PULSE_CYC > (1 << CNT_W)) begin : g_bad_period
    $error("pulse period does not fit the prescaler");
  end

  localparam logic [CNT_W-1:0] LIMIT_FAST = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] LIMIT_SLOW = CNT_W'(2 * PULSE_CYC - 1);

  // ****************************************************************
  // operative decode
  // ****************************************************************
  logic ours;
  logic is_start;
  logic is_stop;
  logic is_wr_ctrl;
  logic is_wr_vec;
  logic is_rd_id;
  logic is_rd_vec;
  logic is_skip;

  // extension bits are not checked: their meaning is open
  assign ours       = pio_valid && (pio_op.dev == PIT_DEV_ADDR);
  assign is_start   = ours && pio_op.optype == PIT_OP_CTRL_PULSE
                      && pio_op.func == PIT_FN_START;
  assign is_stop    = ours && pio_op.optype == PIT_OP_CTRL_PULSE
                      && pio_op.func == PIT_FN_STOP;
  assign is_wr_ctrl = ours && pio_op.optype == PIT_OP_OUTPUT
                      && pio_op.func == PIT_FN_CTRL;
  assign is_wr_vec  = ours && pio_op.optype == PIT_OP_OUTPUT
                      && pio_op.func == PIT_FN_VECTOR;
  assign is_rd_id   = ours && pio_op.optype == PIT_OP_INPUT
                      && pio_op.func == PIT_FN_ID;
  assign is_rd_vec  = ours && pio_op.optype == PIT_OP_INPUT
                      && pio_op.func == PIT_FN_VECTOR;
  assign is_skip    = ours && pio_op.optype == PIT_OP_SKIP
                      && pio_op.func == PIT_FN_NOTIRQ;

  // ****************************************************************
  // wishbone access decode
  // ****************************************************************
  logic wb_req;
  logic wb_wr_ctrl;
  logic wb_wr_vec;
  logic wb_ack_q;

  // ack high masks the still-held strobe, so one request is taken once
  assign wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign wb_wr_ctrl = wb_req && wb_we_i && wb_adr_i == PIT_OFS_CTRL;
  assign wb_wr_vec  = wb_req && wb_we_i && wb_adr_i == PIT_OFS_VECTOR;

  // byte-lane merge of a bus write into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction : lane_merge

  // ****************************************************************
  // control and vector registers
  // ****************************************************************
  logic [15:0] ctrl_q;
  logic [15:0] vector_q;

  // an operative wins over a bus write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= PIT_CTRL_RST;
    end else if (is_wr_ctrl) begin
      ctrl_q <= backplane_data_lines;
    end else if (wb_wr_ctrl) begin
      ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_q <= PIT_VECTOR_RST;
    end else if (is_wr_vec) begin
      vector_q <= backplane_data_lines;
    end else if (wb_wr_vec) begin
      vector_q <= lane_merge(vector_q, wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************************************
  // run state and pulse prescaler
  // ****************************************************************
  logic             running_q;
  logic [CNT_W-1:0] presc_q;
  logic [CNT_W-1:0] limit;
  logic             pulse_q;

  assign limit = ctrl_q[PIT_CTRL_SLOW_BIT] ? LIMIT_SLOW : LIMIT_FAST;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running_q <= 1'b0;
    end else if (is_start) begin
      running_q <= 1'b1;
    end else if (is_stop) begin
      running_q <= 1'b0;
    end
  end

  // restart counts a full period, so the first pulse is never short
  // a rate change acts on the running period, not only the next one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_q <= '0;
      pulse_q <= 1'b0;
    end else if (!running_q || is_start) begin
      presc_q <= '0;
      pulse_q <= 1'b0;
    end else if (presc_q >= limit) begin
      presc_q <= '0;
      pulse_q <= 1'b1;
    end else begin
      presc_q <= presc_q + 1'b1;
      pulse_q <= 1'b0;
    end
  end

  assign timing_pulse = pulse_q;

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  logic irq_q;

  // a new pulse wins over an acknowledge in the same cycle; stop clears all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (is_stop || !running_q) begin
      irq_q <= 1'b0;
    end else if (pulse_q && ctrl_q[PIT_CTRL_ENA_BIT]) begin
      irq_q <= 1'b1;
    end else if (irq_ack) begin
      irq_q <= 1'b0;
    end
  end

  assign irq_req = irq_q;

  // vector is driven while the host services the request
  // the copy lags a vector write by one cycle, far less than a service
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backplane_address_lines <= '0;
    end else begin
      backplane_address_lines <= vector_q;
    end
  end

  assign vector_valid = irq_ack && irq_q;

  // ****************************************************************
  // operative reply, one cycle after the operative
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pio_reply <= '0;
    end else begin
      pio_reply.done  <= ours;
      // unknown function codes still complete, with zero data
      // device 20 input and output complete without a busy phase
      pio_reply.ready <= (ours && pio_op.optype[1])
                         || (is_skip && !irq_q);
      if (is_rd_id) begin
        pio_reply.data <= ID_VALUE;
      end else if (is_rd_vec) begin
        pio_reply.data <= vector_q;
      end else begin
        pio_reply.data <= '0;
      end
    end
  end

  // ****************************************************************
  // wishbone read and acknowledge
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_q <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_q <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          PIT_OFS_CTRL:   wb_dat_o <= {16'h0000, ctrl_q};
          PIT_OFS_VECTOR: wb_dat_o <= {16'h0000, vector_q};
          PIT_OFS_STATUS: wb_dat_o <= {30'h0, irq_q, running_q};
          PIT_OFS_ID:     wb_dat_o <= {16'h0000, ID_VALUE};
          default:        wb_dat_o <= '0;  // unmapped reads as zero
        endcase
      end
    end
  end

  assign wb_ack_o = wb_ack_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [CNT_W-1:0] gap_q;  // cycles since the last pulse

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
    end else if (!running_q || is_start) begin
      gap_q <= '0;
    end else if (pulse_q) begin
      gap_q <= CNT_W'(1);  // the pulse cycle itself opens the next gap
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  sequence s_id_read;
    is_rd_id ##1 pio_reply.done;
  endsequence

  sequence s_vec_read;
    is_rd_vec ##1 pio_reply.done;
  endsequence

  a_id_readback: assert property (s_id_read |-> pio_reply.data == ID_VALUE)
    else $error("id not returned");
  a_vec_readback: assert property (s_vec_read |-> pio_reply.data == $past(vector_q))
    else $error("vector not returned");
  a_start_runs: assert property (is_start |=> running_q)
    else $error("start did not run timer");
  a_stop_clears: assert property (is_stop |=> !running_q && !irq_q)
    else $error("stop left timer active");
  a_ctrl_load: assert property (is_wr_ctrl |=> ctrl_q == $past(backplane_data_lines))
    else $error("control not loaded");
  a_vec_load: assert property (is_wr_vec |=> vector_q == $past(backplane_data_lines))
    else $error("vector not loaded");
  a_skip_state: assert property (is_skip |=> pio_reply.ready == !$past(irq_q))
    else $error("skip condition wrong");
  a_foreign_dev: assert property (pio_valid && pio_op.dev != PIT_DEV_ADDR
                                  |=> !pio_reply.done)
    else $error("foreign operative answered");
  a_pulse_irq: assert property (pulse_q && ctrl_q[PIT_CTRL_ENA_BIT] && running_q
                                && !is_stop |=> irq_q)
    else $error("pulse raised no request");
  a_irq_held: assert property (irq_q && !irq_ack && !is_stop |=> irq_q)
    else $error("request dropped early");
  a_pulse_space: assert property (pulse_q |=> !pulse_q [*2])
    else $error("pulses too close");
  a_pulse_period: assert property (pulse_q && $past(running_q)
                                   |-> $past(gap_q) == limit)
    else $error("pulse period wrong");
  a_io_ready: assert property (ours && pio_op.optype[1] |=> pio_reply.ready)
    else $error("transfer not ready");

  // request, pulse and handshake checks that the scenarios reach
  a_skip_busy: assert property (is_skip && irq_q |=> !pio_reply.ready)
    else $error("skip satisfied while interrupting");
  a_ack_clears: assert property (irq_q && irq_ack && !pulse_q |=> !irq_q)
    else $error("acknowledge left request");
  a_idle_quiet: assert property (!running_q |=> !pulse_q)
    else $error("pulse while stopped");
  a_vec_lines: assert property (vector_valid
                                |-> backplane_address_lines == $past(vector_q))
    else $error("vector not on address lines");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge stretched");
  // a foreign operative must leave the timer untouched
  a_foreign_keep: assert property (pio_valid && pio_op.dev != PIT_DEV_ADDR && !wb_req
                                   |=> $stable(ctrl_q) && $stable(running_q))
    else $error("foreign operative changed state");

endmodule : pit_interval_timer

/* File: pit_pkg.sv */
// ****************************************************************
// interval timer shared definitions
// ****************************************************************
package pit_pkg;

  // basic operation carried in the top two operative bits
  typedef enum logic [1:0] {
    PIT_OP_CTRL_PULSE = 2'b00,  // output_control_pulse
    PIT_OP_SKIP       = 2'b01,  // skip_if_satisfied
    PIT_OP_INPUT      = 2'b10,  // input_to_acc
    PIT_OP_OUTPUT     = 2'b11   // output_from_acc
  } pit_optype_e;

  // one programmed-I/O operative, operative bit 1 is the msb
  typedef struct packed {
    pit_optype_e optype;   // bits 1-2
    logic [3:0]  ext;      // bits 3-6, fixed pattern or type extension
    logic [3:0]  func;     // bits 7-10
    logic [5:0]  dev;      // bits 11-16
  } pit_oper_s;

  // answer of the timer to an operative
  typedef struct packed {
    logic        done;     // operative was addressed to this timer
    logic        ready;    // transfer or skip condition satisfied
    logic [15:0] data;     // value for the accumulator
  } pit_reply_s;

  // device address and function codes understood by the timer
  localparam logic [5:0] PIT_DEV_ADDR   = 6'h10;
  localparam logic [3:0] PIT_FN_START   = 4'h0;  // control pulse
  localparam logic [3:0] PIT_FN_STOP    = 4'h2;  // control pulse
  localparam logic [3:0] PIT_FN_CTRL    = 4'h7;  // output to control
  localparam logic [3:0] PIT_FN_ID      = 4'h9;  // input of the id
  localparam logic [3:0] PIT_FN_VECTOR  = 4'hb;  // input or output of vector
  localparam logic [3:0] PIT_FN_NOTIRQ  = 4'h0;  // skip when not interrupting

  // control register fields
  localparam int unsigned PIT_CTRL_ENA_BIT  = 0;  // interrupt enable
  localparam int unsigned PIT_CTRL_SLOW_BIT = 1;  // 250 Hz rate variant

  // reset values
  localparam logic [15:0] PIT_CTRL_RST   = 16'h0000;
  localparam logic [15:0] PIT_VECTOR_RST = 16'h0000;

  // wishbone register byte offsets
  localparam logic [3:0] PIT_OFS_CTRL   = 4'h0;
  localparam logic [3:0] PIT_OFS_VECTOR = 4'h4;
  localparam logic [3:0] PIT_OFS_STATUS = 4'h8;
  localparam logic [3:0] PIT_OFS_ID     = 4'hc;

  // status register fields
  localparam int unsigned PIT_STAT_RUN_BIT = 0;
  localparam int unsigned PIT_STAT_IRQ_BIT = 1;

  // timing: pulse period and system clock period in ns
  localparam int unsigned PIT_PULSE_PERIOD_NS = 2000000;
  localparam int unsigned PIT_CLK_PERIOD_NS   = 100;
  localparam int unsigned PIT_PULSE_CYC       = PIT_PULSE_PERIOD_NS / PIT_CLK_PERIOD_NS;

endpackage : pit_pkg

/* File: pit_host_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// host processor issuing operatives and servicing the interrupt
// ****************************************************************
module pit_host_model (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ints_on,
  input  wire logic           irq_req,
  input  wire logic           vector_valid,
  input  wire logic [15:0]    backplane_address_lines,
  input  pit_pkg::pit_reply_s pio_reply,
  output logic                pio_valid,
  output pit_pkg::pit_oper_s  pio_op,
  output logic [15:0]         backplane_data_lines,
  output logic                irq_ack
);
  import pit_pkg::*;
  logic [1:0]  step_q;
  logic [15:0] vec_q;
  int          served;

  // idle bus at time zero
  initial begin
    pio_valid = 1'b0;
    pio_op = '0;
    backplane_data_lines = 16'h0000;
  end

  // one operative, strobe held one cycle, reply taken where it stands
  // operatives go out strictly in order, none skipped after device 20
  task automatic issue(input pit_optype_e t, input logic [3:0] x, input logic [3:0] f,
                       input logic [5:0] d, input logic [15:0] acc, output pit_reply_s r);
    @(posedge clk);
    pio_valid <= 1'b1;
    pio_op <= '{t, x, f, d};
    backplane_data_lines <= acc;
    @(posedge clk);
    pio_valid <= 1'b0;
    backplane_data_lines <= ~acc;  // released lines must not look valid
    @(negedge clk);
    r = pio_reply;
  endtask : issue

  // fetch boundary every fourth cycle; trap only there and only if enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_q <= 2'h0;
      irq_ack <= 1'b0;
      vec_q <= 16'h0000;
      served <= 0;
    end else begin
      step_q <= step_q + 2'h1;
      irq_ack <= ints_on && irq_req && !irq_ack && (step_q == 2'h0);
      if (vector_valid) begin
        vec_q <= backplane_address_lines;
        served <= served + 1;
      end
    end
  end
endmodule : pit_host_model

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  import pit_pkg::*;
  localparam int unsigned PC  = 20;
  localparam logic [15:0] IDV = 16'h005a;  // arbitrary id value
  logic               clk, rst, cyc, stb, we, ints_on, wb_ack_o, pio_valid, irq_ack;
  logic               irq_req, timing_pulse, vector_valid;
  logic [3:0]         adr;
  logic [31:0]        wdat, wb_dat_o, rd;
  logic [15:0]        bdl, bal;
  pit_oper_s          pio_op;
  pit_reply_s         pio_reply, r;
  int                 bad_count, samples_checked, n, i;

  // ****************************************************************
  // clock, design and host
  // ****************************************************************
  always #50 clk = ~clk;

  pit_interval_timer #(.PULSE_CYC(PC), .ID_VALUE(IDV)) DUT (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pio_valid(pio_valid), .pio_op(pio_op), .backplane_data_lines(bdl),
    .pio_reply(pio_reply), .irq_ack(irq_ack), .irq_req(irq_req),
    .timing_pulse(timing_pulse), .backplane_address_lines(bal), .vector_valid(vector_valid));

  pit_host_model host (
    .clk(clk), .rst(rst), .ints_on(ints_on), .irq_req(irq_req), .vector_valid(vector_valid),
    .backplane_address_lines(bal), .pio_reply(pio_reply), .pio_valid(pio_valid),
    .pio_op(pio_op), .backplane_data_lines(bdl), .irq_ack(irq_ack));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // classic cycle: held until ack is sampled, released after it
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk("wb ack", 32'h1, {31'h0, wb_ack_o});
      test_done();
    end
  endtask : wb

  // cycles until the next timing pulse, bounded
  task automatic wpulse;
    for (n = 1; n < 200; n++) begin
      @(negedge clk);
      if (timing_pulse === 1'b1) return;
    end
    chk("pulse seen", 32'h1, {31'h0, timing_pulse});
    test_done();
  endtask : wpulse

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset state, including an unmapped read
  task automatic t_reset;
    chk("irq after reset", 32'h0, {31'h0, irq_req});
    wb(1'b0, PIT_OFS_CTRL, 16'h0);
    chk("ctrl reset", 32'h0, rd);
    wb(1'b0, PIT_OFS_VECTOR, 16'h0);
    chk("vector reset", 32'h0, rd);
    wb(1'b0, PIT_OFS_STATUS, 16'h0);
    chk("status reset", 32'h0, rd);
    wb(1'b0, PIT_OFS_ID, 16'h0);
    chk("bus id", {16'h0, IDV}, rd);
    wb(1'b0, 4'h2, 16'h0);
    chk("unmapped read", 32'h0, rd);
  endtask : t_reset

  // id, foreign device, vector and control loads
  task automatic t_regs;
    host.issue(PIT_OP_INPUT, 4'hc, PIT_FN_ID, PIT_DEV_ADDR, 16'h0, r);
    chk("id reply", {14'h0, 2'b11, IDV}, {14'h0, r});
    host.issue(PIT_OP_INPUT, 4'hc, PIT_FN_ID, PIT_DEV_ADDR ^ 6'h01, 16'h0, r);
    chk("foreign reply", 32'h0, {14'h0, r});
    host.issue(PIT_OP_OUTPUT, 4'hc, PIT_FN_VECTOR, PIT_DEV_ADDR, 16'h1234, r);
    chk("vector load ready", 32'h3, {30'h0, r.done, r.ready});
    host.issue(PIT_OP_INPUT, 4'hc, PIT_FN_VECTOR, PIT_DEV_ADDR, 16'h0, r);
    chk("vector read", {14'h0, 2'b11, 16'h1234}, {14'h0, r});
    host.issue(PIT_OP_OUTPUT, 4'hc, PIT_FN_CTRL, PIT_DEV_ADDR, 16'h0001, r);
    wb(1'b0, PIT_OFS_CTRL, 16'h0);
    chk("ctrl load", 32'h1, rd);
  endtask : t_regs

  // start, period, request, skip and service
  task automatic t_run;
    host.issue(PIT_OP_SKIP, 4'hc, PIT_FN_NOTIRQ, PIT_DEV_ADDR, 16'h0, r);
    chk("skip idle", 32'h3, {30'h0, r.done, r.ready});
    host.issue(PIT_OP_CTRL_PULSE, 4'hc, PIT_FN_START, PIT_DEV_ADDR, 16'h0, r);
    wb(1'b0, PIT_OFS_STATUS, 16'h0);
    chk("running", 32'h1, rd & 32'h1);
    wpulse();
    @(negedge clk);
    chk("request", 32'h1, {31'h0, irq_req});
    wpulse();
    chk("fast period", PC, n + 1);
    host.issue(PIT_OP_SKIP, 4'hc, PIT_FN_NOTIRQ, PIT_DEV_ADDR, 16'h0, r);
    chk("skip busy", 32'h2, {30'h0, r.done, r.ready});
    chk("held", 32'h1, {31'h0, irq_req});
    @(posedge clk);
    ints_on <= 1'b1;
    for (i = 0; i < 20 && host.served == 0; i++) @(negedge clk);
    chk("vector on lines", 32'h1234, {16'h0, host.vec_q});
    chk("cleared by ack", 32'h0, {31'h0, irq_req});
  endtask : t_run

  // slow rate through the register bus
  task automatic t_slow;
    wb(1'b1, PIT_OFS_CTRL, 16'h0003);
    wpulse();
    wpulse();
    chk("slow period", 2 * PC, n);
  endtask : t_slow

  // stop in extended mode with a request pending
  task automatic t_stop;
    @(posedge clk);
    ints_on <= 1'b0;
    wpulse();
    host.issue(PIT_OP_CTRL_PULSE, 4'h5, PIT_FN_STOP, PIT_DEV_ADDR, 16'h0, r);
    chk("stop clears", 32'h0, {31'h0, irq_req});
    wb(1'b0, PIT_OFS_STATUS, 16'h0);
    chk("stopped", 32'h0, rd);
    n = 0;
    repeat (3 * PC) @(negedge clk) n += int'(timing_pulse === 1'b1);
    chk("no pulse stopped", 32'h0, n);
  endtask : t_stop

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, ints_on, adr, wdat} = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_regs();
    t_run();
    t_slow();
    t_stop();
    test_done();
  end
endmodule : tb
